// file: design/dev_port_pkg.sv
// shared constants and types for the development port sequencer and freeze control
package dev_port_pkg;
   // ==========================================================
   // frame layout: start bit, two kind bits, data word
   localparam int          DATA_W      = 32;
   localparam int          KIND_W      = 2;
   localparam int          STAT_W      = 2;
   localparam int          FRAME_LEN   = 1 + KIND_W + DATA_W;
   localparam int          CNT_W       = 6;
   localparam logic [CNT_W-1:0] LAST_BIT = 6'h22;
   // ==========================================================
   // kind codes shifted in after the start bit
   localparam logic [KIND_W-1:0] KIND_INSTR = 2'h0;
   localparam logic [KIND_W-1:0] KIND_DATA  = 2'h1;
   localparam logic [KIND_W-1:0] KIND_TRAP  = 2'h2;
   // ==========================================================
   // status codes shifted out ahead of the data word
   localparam logic [STAT_W-1:0] STAT_DATA   = 2'h0;
   localparam logic [STAT_W-1:0] STAT_SEQERR = 2'h1;
   localparam logic [STAT_W-1:0] STAT_EXC    = 2'h2;
   localparam logic [STAT_W-1:0] STAT_NULL   = 2'h3;
   // ==========================================================
   // freeze status pins code and reset values
   localparam logic [1:0]        FREEZE_CODE  = 2'h3;
   localparam logic [1:0]        NOFREEZE     = 2'h0;
   localparam logic [DATA_W-1:0] TRAP_RESET   = 32'h00000000;
   localparam logic [DATA_W-1:0] WORD_RESET   = 32'h00000000;
   // ==========================================================
   // port usage steps, one-hot
   typedef enum logic [6:0] {
      STEP_FETCH    = 7'h01,
      STEP_READ     = 7'h02,
      STEP_CPUDATA  = 7'h04,
      STEP_EXC      = 7'h08,
      STEP_SEQ      = 7'h10,
      STEP_IDLE     = 7'h20,
      STEP_NORMERR  = 7'h40
   } step_t;
endpackage

// file: design/dev_port_sequencer_freeze.sv
// development port step sequencer with freeze indication, top level
// Notes on behaviour
// - outside debug mode, CPU instruction or data is ignored and latches sequence error
// - outside debug mode, trap enable data updates the register; idle step stays
// - normal error step ignores input, reports sequence error, returns to idle
// - status codes differ for null, exception, sequence error and CPU data
// - port can error-terminate CPU reads, pass instructions/data, load trap enables
// - any enabled debug event asserts freeze, debug mode enabled or not
// - an event freezes only when its debug enable bit is set
// - return-from-interrupt releases freeze only if the cause register was cleared
// - software reads cause register to clear it, then returns to release
// - with debug mode off, events raise ordinary exceptions; registers only drive freeze
// - freeze shows on status pins only while in debug mode
// - freeze reaches each module, which halts when programmed to
// - save/restore registers change in debug mode only when written
// - status shifted out follows what the previous frame shifted in
// - data during a debug fetch is ignored; fetch errored; sequence error latched
// - debug mode, shown on status pins, selects the usage table
`timescale 1ns/10ps
`default_nettype none
module dev_port_sequencer_freeze
   import dev_port_pkg::*;
#(
   parameter int EVT_W = 8,
   parameter int MOD_W = 4
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              portSerialClk,
   input  wire logic              portSerialIn,
   output logic                   portSerialOut,
   output logic                   portReadyOut,
   input  wire logic              cpuFetchReq,
   input  wire logic              cpuReadReq,
   input  wire logic              cpuWriteStb,
   input  wire logic [DATA_W-1:0] cpuWriteData,
   input  wire logic              cpuExcStb,
   output logic                   instrStb,
   output logic [DATA_W-1:0]      instrWord,
   output logic                   readDataStb,
   output logic [DATA_W-1:0]      readData,
   output logic                   cpuErrStb,
   output logic [DATA_W-1:0]      trapEnableCtrl,
   output logic                   seqErrFlag,
   input  wire logic [EVT_W-1:0]  events,
   input  wire logic [EVT_W-1:0]  debugEnable,
   input  wire logic              debugModeEnable,
   input  wire logic              causeRead,
   input  wire logic              rfiExec,
   input  wire logic [DATA_W-1:0] pc,
   input  wire logic [DATA_W-1:0] msr,
   input  wire logic              srr0Write,
   input  wire logic              srr1Write,
   input  wire logic [DATA_W-1:0] srrData,
   input  wire logic [MOD_W-1:0]  haltEnable,
   output logic                   freezeInternal,
   output logic [1:0]             freezeStatusPins,
   output logic [MOD_W-1:0]       moduleHalt,
   output logic [EVT_W-1:0]       causeReg,
   output logic                   exceptionReq,
   output logic [DATA_W-1:0]      saveRestore0,
   output logic [DATA_W-1:0]      saveRestore1
);
   step_t                   step;
   step_t                   next_step;
   logic                    waitCpu;
   logic                    debugSeen;
   logic [DATA_W-1:0]       cpuWord;
   logic                    frameStb;
   logic [KIND_W-1:0]       frameKind;
   logic [DATA_W-1:0]       frameData;
   logic                    inDebug;
   logic [STAT_W-1:0]       statusCode;
   logic                    next_instr;
   logic                    next_read;
   logic                    next_err;
   logic                    next_seq;
   logic                    next_wait;

   // ==========================================================
   // frame decode
   wire isInstr = frameStb & (frameKind == KIND_INSTR);
   wire isTrap  = frameStb & (frameKind == KIND_TRAP);
   wire isData  = frameStb & ~isInstr & ~isTrap;
   wire enterDbg = inDebug & ~debugSeen;
   wire leaveDbg = ~inDebug & debugSeen;

   // status for the next frame from current step
   always_comb begin
      case (step)
         STEP_CPUDATA: statusCode = STAT_DATA;
         STEP_EXC:     statusCode = STAT_EXC;
         STEP_SEQ:     statusCode = STAT_SEQERR;
         STEP_NORMERR: statusCode = STAT_SEQERR;
         default:      statusCode = STAT_NULL;
      endcase
   end

   wire [DATA_W-1:0] outData = (step == STEP_CPUDATA) ? cpuWord : WORD_RESET;
   wire [STAT_W+DATA_W-1:0] loadWord = {statusCode, outData};

   port_shifter u_shifter (
      .clk           (clk),
      .rst           (rst),
      .ce            (ce),
      .portSerialClk (portSerialClk),
      .portSerialIn  (portSerialIn),
      .ready         (~waitCpu),
      .loadWord      (loadWord),
      .portSerialOut (portSerialOut),
      .frameStb      (frameStb),
      .frameKind     (frameKind),
      .frameData     (frameData)
   );

   freeze_ctrl #(.EVT_W(EVT_W)) u_freeze (
      .clk             (clk),
      .rst             (rst),
      .ce              (ce),
      .events          (events),
      .debugEnable     (debugEnable),
      .debugModeEnable (debugModeEnable),
      .causeRead       (causeRead),
      .rfiExec         (rfiExec),
      .pc              (pc),
      .msr             (msr),
      .srr0Write       (srr0Write),
      .srr1Write       (srr1Write),
      .srrData         (srrData),
      .freeze          (freezeInternal),
      .inDebug         (inDebug),
      .causeReg        (causeReg),
      .exceptionReq    (exceptionReq),
      .saveRestore0    (saveRestore0),
      .saveRestore1    (saveRestore1)
   );

   // ==========================================================
   // step sequencing
   always_comb begin
      next_step  = step;
      next_instr = 1'b0;
      next_read  = 1'b0;
      next_err   = 1'b0;
      next_seq   = 1'b0;
      next_wait  = waitCpu;
      if (enterDbg) begin
         next_step = STEP_FETCH;
         next_wait = 1'b0;
      end else if (leaveDbg) begin
         next_step = STEP_IDLE;
         next_wait = 1'b0;
      end else if (waitCpu) begin
         if (cpuWriteStb) begin
            next_step = STEP_CPUDATA;
            next_wait = 1'b0;
         end else if (cpuExcStb) begin
            next_step = STEP_EXC;
            next_wait = 1'b0;
         end else if (cpuReadReq) begin
            next_step = STEP_READ;
            next_wait = 1'b0;
         end else if (cpuFetchReq) begin
            next_step = STEP_FETCH;
            next_wait = 1'b0;
         end
      end else if (frameStb) begin
         case (step)
            STEP_IDLE: begin
               if (!isTrap) begin
                  next_step = STEP_NORMERR;
                  next_seq  = 1'b1;
               end
            end
            STEP_NORMERR: next_step = STEP_IDLE;
            STEP_FETCH, STEP_CPUDATA: begin
               if (isInstr) begin
                  next_instr = 1'b1;
                  next_wait  = 1'b1;
               end else if (isData) begin
                  next_err  = 1'b1;
                  next_seq  = 1'b1;
                  next_step = STEP_SEQ;
               end else begin
                  next_step = STEP_FETCH;
               end
            end
            STEP_READ: begin
               if (isInstr) begin
                  next_err  = 1'b1;
                  next_seq  = 1'b1;
                  next_step = STEP_SEQ;
               end else if (isData) begin
                  next_read = 1'b1;
                  next_step = STEP_FETCH;
               end
            end
            STEP_EXC: next_step = STEP_FETCH;
            STEP_SEQ: next_step = STEP_EXC;
            default:  next_step = STEP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         step        <= STEP_IDLE;
         waitCpu     <= 1'b0;
         debugSeen   <= 1'b0;
         seqErrFlag  <= 1'b0;
         instrStb    <= 1'b0;
         readDataStb <= 1'b0;
         cpuErrStb   <= 1'b0;
      end else if (ce) begin
         step        <= next_step;
         waitCpu     <= next_wait;
         debugSeen   <= inDebug;
         instrStb    <= next_instr;
         readDataStb <= next_read;
         cpuErrStb   <= next_err;
         if (next_seq)
            seqErrFlag <= 1'b1;
         else if (next_step != STEP_SEQ && next_step != STEP_NORMERR)
            seqErrFlag <= 1'b0;
      end
   end

   // ==========================================================
   // data words, trap enables, pins
   always_ff @(posedge clk) begin
      if (rst) begin
         instrWord      <= WORD_RESET;
         readData       <= WORD_RESET;
         cpuWord        <= WORD_RESET;
         trapEnableCtrl <= TRAP_RESET;
         portReadyOut   <= 1'b0;
         freezeStatusPins <= NOFREEZE;
      end else if (ce) begin
         if (next_instr)
            instrWord <= frameData;
         if (next_read)
            readData <= frameData;
         if (waitCpu && cpuWriteStb)
            cpuWord <= cpuWriteData;
         if (isTrap && !enterDbg && !leaveDbg && !waitCpu && step != STEP_NORMERR
             && step != STEP_SEQ && step != STEP_EXC)
            trapEnableCtrl <= frameData;
         portReadyOut <= ~next_wait;
         freezeStatusPins <= (inDebug & freezeInternal) ? FREEZE_CODE : NOFREEZE;
      end
   end

   genvar m;
   generate
      for (m = 0; m < MOD_W; m++) begin : g_halt
         always_ff @(posedge clk) begin
            if (rst)
               moduleHalt[m] <= 1'b0;
            else if (ce)
               moduleHalt[m] <= freezeInternal & haltEnable[m];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// file: design/freeze_ctrl.sv
// freeze, cause register, debug mode entry and save/restore registers
`timescale 1ns/10ps
`default_nettype none
module freeze_ctrl
   import dev_port_pkg::*;
#(
   parameter int EVT_W = 8
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [EVT_W-1:0]  events,
   input  wire logic [EVT_W-1:0]  debugEnable,
   input  wire logic              debugModeEnable,
   input  wire logic              causeRead,
   input  wire logic              rfiExec,
   input  wire logic [DATA_W-1:0] pc,
   input  wire logic [DATA_W-1:0] msr,
   input  wire logic              srr0Write,
   input  wire logic              srr1Write,
   input  wire logic [DATA_W-1:0] srrData,
   output logic                   freeze,
   output logic                   inDebug,
   output logic [EVT_W-1:0]       causeReg,
   output logic                   exceptionReq,
   output logic [DATA_W-1:0]      saveRestore0,
   output logic [DATA_W-1:0]      saveRestore1
);
   wire             enabledHit = |(events & debugEnable);
   wire             anyEvent   = |events;
   wire             release_   = rfiExec & (causeReg == '0) & ~enabledHit;
   wire             enterDebug = enabledHit & debugModeEnable;
   wire             excTake    = anyEvent & ~debugModeEnable;
   wire [EVT_W-1:0] next_cause = (causeRead ? '0 : causeReg) | events;

   always_ff @(posedge clk) begin
      if (rst) begin
         freeze       <= 1'b0;
         inDebug      <= 1'b0;
         causeReg     <= '0;
         exceptionReq <= 1'b0;
      end else if (ce) begin
         causeReg     <= next_cause;
         exceptionReq <= excTake;
         if (enabledHit)
            freeze <= 1'b1;
         else if (release_)
            freeze <= 1'b0;
         if (enterDebug)
            inDebug <= 1'b1;
         else if (release_)
            inDebug <= 1'b0;
      end
   end

   // ==========================================================
   // save/restore registers held in debug mode unless written
   always_ff @(posedge clk) begin
      if (rst) begin
         saveRestore0 <= WORD_RESET;
         saveRestore1 <= WORD_RESET;
      end else if (ce) begin
         if (srr0Write)
            saveRestore0 <= srrData;
         else if (excTake && !inDebug)
            saveRestore0 <= pc;
         if (srr1Write)
            saveRestore1 <= srrData;
         else if (excTake && !inDebug)
            saveRestore1 <= msr;
      end
   end
endmodule
`default_nettype wire

// file: design/port_shifter.sv
// serial shifter for the development port: pin sync, frame capture, status shift out
`timescale 1ns/10ps
`default_nettype none
module port_shifter
   import dev_port_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              portSerialClk,
   input  wire logic              portSerialIn,
   input  wire logic              ready,
   input  wire logic [STAT_W+DATA_W-1:0] loadWord,
   output logic                   portSerialOut,
   output logic                   frameStb,
   output logic [KIND_W-1:0]      frameKind,
   output logic [DATA_W-1:0]      frameData
);
   logic [1:0]              clkSync;
   logic [1:0]              dinSync;
   logic                    clkLast;
   logic                    busy;
   logic [CNT_W-1:0]        bitCnt;
   logic [FRAME_LEN-2:0]    inShift;
   logic [STAT_W+DATA_W-1:0] outShift;
   wire                     rise = clkSync[1] & ~clkLast;
   wire                     startBit = rise & ~busy & ready & dinSync[1];
   wire                     lastBit = rise & busy & (bitCnt == LAST_BIT);

   always_ff @(posedge clk) begin
      if (rst) begin
         clkSync <= 2'h0;
         dinSync <= 2'h0;
         clkLast <= 1'b0;
      end else if (ce) begin
         clkSync <= {clkSync[0], portSerialClk};
         dinSync <= {dinSync[0], portSerialIn};
         clkLast <= clkSync[1];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy          <= 1'b0;
         bitCnt        <= '0;
         inShift       <= '0;
         outShift      <= '0;
         portSerialOut <= 1'b0;
         frameStb      <= 1'b0;
         frameKind     <= KIND_INSTR;
         frameData     <= WORD_RESET;
      end else if (ce) begin
         frameStb <= 1'b0;
         if (startBit) begin
            busy          <= 1'b1;
            bitCnt        <= 6'h1;
            portSerialOut <= loadWord[STAT_W+DATA_W-1];
            outShift      <= {loadWord[STAT_W+DATA_W-2:0], 1'b0};
         end else if (rise && busy) begin
            inShift       <= {inShift[FRAME_LEN-3:0], dinSync[1]};
            portSerialOut <= outShift[STAT_W+DATA_W-1];
            outShift      <= {outShift[STAT_W+DATA_W-2:0], 1'b0};
            bitCnt        <= bitCnt + 6'h1;
            if (lastBit) begin
               busy      <= 1'b0;
               frameStb  <= 1'b1;
               frameKind <= inShift[FRAME_LEN-3 -: KIND_W];
               frameData <= {inShift[DATA_W-2:0], dinSync[1]};
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench/dev_host.sv
// debug host model driving the serial development port
`timescale 1ns/10ps
`default_nettype none
module dev_host
   import dev_port_pkg::*;
(
   input  wire logic clk,
   input  wire logic portSerialOut,
   output logic      portSerialClk,
   output logic      portSerialIn
);
   localparam int HALF = 5;
   logic [STAT_W-1:0] lastStat;
   initial begin
      portSerialClk = 1'h0;
      portSerialIn = 1'h0;
   end
   // ==========================================================
   // one frame; clock stands still between frames
   task automatic send(input logic [KIND_W-1:0] kind, input logic [DATA_W-1:0] data);
      logic [FRAME_LEN-1:0] bits;
      bits = {1'h1, kind, data};
      for (int i = FRAME_LEN - 1; i >= 0; i--) begin
         portSerialIn <= bits[i];
         repeat (HALF) @(posedge clk);
         if (i == FRAME_LEN - 2) lastStat[1] = portSerialOut;
         if (i == FRAME_LEN - 3) lastStat[0] = portSerialOut;
         portSerialClk <= 1'h1;
         repeat (HALF) @(posedge clk);
         portSerialClk <= 1'h0;
      end
      // released line is driven to the inverse of the last bit
      portSerialIn <= ~bits[0];
      repeat (HALF) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// file: testbench/dev_port_checker.sv
// concurrent checks on the sequencer and freeze control ports
`timescale 1ns/10ps
`default_nettype none
module dev_port_checker
   import dev_port_pkg::*;
#(
   parameter int EVT_W = 8,
   parameter int MOD_W = 4
)(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic [EVT_W-1:0]  events,
   input wire logic [EVT_W-1:0]  debugEnable,
   input wire logic              debugModeEnable,
   input wire logic              rfiExec,
   input wire logic              freezeInternal,
   input wire logic [1:0]        freezeStatusPins,
   input wire logic [EVT_W-1:0]  causeReg,
   input wire logic              exceptionReq,
   input wire logic [MOD_W-1:0]  haltEnable,
   input wire logic [MOD_W-1:0]  moduleHalt,
   input wire logic              srr0Write,
   input wire logic [DATA_W-1:0] saveRestore0,
   input wire logic              instrStb,
   input wire logic              readDataStb,
   input wire logic              seqErrFlag
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic enHit = |(events & debugEnable);

   chk_freeze_event: assert property (enHit |=> freezeInternal)
      else $error("enabled event gave no freeze");
   chk_freeze_cause: assert property ($rose(freezeInternal) |-> $past(enHit))
      else $error("freeze rose without enabled event");
   chk_pins_freeze: assert property (freezeStatusPins != NOFREEZE |->
      freezeStatusPins == FREEZE_CODE && (freezeInternal || $past(freezeInternal)))
      else $error("status pins show freeze wrongly");
   chk_pins_mode: assert property ($rose(freezeStatusPins[0]) |-> $past(debugModeEnable, 2))
      else $error("status pins raised with debug mode off");
   chk_rfi_hold: assert property (rfiExec && causeReg != 8'h00 && freezeInternal |=> freezeInternal)
      else $error("return released freeze with cause set");
   chk_rfi_release: assert property (rfiExec && causeReg == 8'h00 && !enHit |=> !freezeInternal)
      else $error("return did not release freeze");
   chk_exc_request: assert property ((|events) && !debugModeEnable |=> exceptionReq)
      else $error("event gave no exception request");
   chk_halt_track: assert property (moduleHalt == ($past(freezeInternal) ? $past(haltEnable) : 4'h0))
      else $error("module halt does not follow freeze");
   chk_srr_hold: assert property (freezeStatusPins == FREEZE_CODE && $past(freezeStatusPins) == FREEZE_CODE
      && !$past(srr0Write) |-> $stable(saveRestore0))
      else $error("save restore changed in debug mode");
   chk_normal_quiet: assert property (freezeStatusPins == NOFREEZE && $past(freezeStatusPins) == NOFREEZE
      |-> !instrStb && !readDataStb)
      else $error("transfer to core outside debug mode");
   chk_reset_idle: assert property ($fell(rst) |-> !seqErrFlag && freezeStatusPins == NOFREEZE)
      else $error("state not idle after reset");
endmodule

bind dev_port_sequencer_freeze dev_port_checker #(.EVT_W(EVT_W), .MOD_W(MOD_W)) dev_port_checker_i (.*);
`default_nettype wire

// file: testbench/dev_port_sequencer_freeze_tb.sv
// self-checking bench for the development port sequencer and freeze control
`timescale 1ns/10ps
`default_nettype none
module dev_port_sequencer_freeze_tb;
   import dev_port_pkg::*;
   localparam int EVT_W = 8;
   localparam int MOD_W = 4;
   typedef struct packed {logic [1:0] kind; logic [1:0] stat; logic [3:0] act;} row_t;
   // ==========================================================
   // signals
   logic              clk = 1'h0, rst = 1'h1, ce = 1'h1;
   logic              portSerialClk, portSerialIn, portSerialOut, portReadyOut;
   logic              cpuFetchReq = 1'h0, cpuReadReq = 1'h0, cpuWriteStb = 1'h0, cpuExcStb = 1'h0;
   logic              debugModeEnable = 1'h0, causeRead = 1'h0, rfiExec = 1'h0;
   logic              srr0Write = 1'h0, srr1Write = 1'h0;
   logic              instrStb, readDataStb, cpuErrStb, seqErrFlag, freezeInternal, exceptionReq;
   logic [DATA_W-1:0] cpuWriteData = 32'h0, pc = 32'h0, msr = 32'h0, srrData = 32'h0;
   logic [DATA_W-1:0] instrWord, readData, trapEnableCtrl, saveRestore0, saveRestore1;
   logic [DATA_W-1:0] gotInstr, gotRead, seed, s0;
   logic [EVT_W-1:0]  events = 8'h0, debugEnable = 8'h0, causeReg;
   logic [MOD_W-1:0]  haltEnable = 4'h0, moduleHalt;
   logic [1:0]        freezeStatusPins;
   int                errors = 0, n_checks = 0, nInstr = 0, nRead = 0, nErr = 0, nExc = 0, x0;
   // act: 0 ignored, 1-4 instruction then core reply, 5 read, 6 fetch error, 7 trap load, 9 seq error
   row_t rows [0:16] = '{
      '{KIND_TRAP, STAT_NULL, 4'h7}, '{KIND_INSTR, STAT_NULL, 4'h9}, '{KIND_TRAP, STAT_SEQERR, 4'h0},
      '{KIND_DATA, STAT_NULL, 4'h9}, '{KIND_INSTR, STAT_SEQERR, 4'h0}, '{KIND_TRAP, STAT_NULL, 4'h7},
      '{KIND_INSTR, STAT_NULL, 4'h4}, '{KIND_INSTR, STAT_NULL, 4'h1}, '{KIND_INSTR, STAT_DATA, 4'h2},
      '{KIND_DATA, STAT_NULL, 4'h5}, '{KIND_DATA, STAT_NULL, 4'h6}, '{KIND_TRAP, STAT_SEQERR, 4'h0},
      '{KIND_INSTR, STAT_EXC, 4'h0}, '{KIND_TRAP, STAT_NULL, 4'h7}, '{KIND_INSTR, STAT_NULL, 4'h3},
      '{KIND_INSTR, STAT_EXC, 4'h0}, '{KIND_TRAP, STAT_NULL, 4'h7}};

   always #2 clk = ~clk;

   dev_port_sequencer_freeze #(.EVT_W(EVT_W), .MOD_W(MOD_W)) dev_port_sequencer_freeze_i (.*);
   dev_host dev_host_i (.*);

   always @(posedge clk) begin
      if (instrStb === 1'h1) begin
         nInstr++;
         gotInstr = instrWord;
      end
      if (readDataStb === 1'h1) begin
         nRead++;
         gotRead = readData;
      end
      if (cpuErrStb === 1'h1) nErr++;
      if (exceptionReq === 1'h1) nExc++;
   end
   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic pulse(input logic [EVT_W-1:0] ev, input logic cr, input logic rf);
      events <= ev;
      causeRead <= cr;
      rfiExec <= rf;
      @(posedge clk);
      events <= 8'h0;
      causeRead <= 1'h0;
      rfiExec <= 1'h0;
      repeat (3) @(posedge clk);
   endtask

   // core reply after an instruction: 1 write, 2 read, 3 exception, 4 fetch
   task automatic core(input logic [3:0] how);
      cpuWriteStb <= (how == 4'h1);
      cpuReadReq <= (how == 4'h2);
      cpuExcStb <= (how == 4'h3);
      cpuFetchReq <= (how == 4'h4);
      cpuWriteData <= lfsr(seed ^ 32'h5);
      @(posedge clk);
      cpuWriteStb <= 1'h0;
      cpuExcStb <= 1'h0;
      @(posedge clk);
      cpuReadReq <= 1'h0;
      cpuFetchReq <= 1'h0;
   endtask

   task automatic run(input int lo, input int hi);
      logic [DATA_W-1:0] t0;
      int n0, r0, e0, k;
      for (int i = lo; i <= hi; i++) begin
         seed = lfsr(seed);
         for (k = 0; k < 200 && portReadyOut !== 1'h1; k++) @(posedge clk);
         if (portReadyOut !== 1'h1) begin
            errors++;
            $display("FAIL ready expected 1 seen %b", portReadyOut);
            print_verdict();
         end
         n0 = nInstr;
         r0 = nRead;
         e0 = nErr;
         t0 = trapEnableCtrl;
         dev_host_i.send(rows[i].kind, seed);
         check("status", dev_host_i.lastStat, rows[i].stat);
         check("instr count", nInstr - n0, rows[i].act inside {[1:4]});
         check("read count", nRead - r0, rows[i].act == 4'h5);
         check("error count", nErr - e0, rows[i].act == 4'h6);
         check("trap", trapEnableCtrl, rows[i].act == 4'h7 ? seed : t0);
         if (rows[i].act inside {6, 9}) check("seq flag", seqErrFlag, 1'h1);
         if (rows[i].act == 4'h5) check("read word", gotRead, seed);
         if (rows[i].act inside {[1:4]}) begin
            check("instr word", gotInstr, seed);
            core(rows[i].act);
         end
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      seed = 32'h4a;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
      check("seq flag", seqErrFlag, 1'h0);
      check("trap reset", trapEnableCtrl, TRAP_RESET);
      run(0, 5);
      seed = lfsr(seed);
      haltEnable <= seed[MOD_W-1:0] | 4'h1;
      pc <= seed;
      msr <= ~seed;
      debugEnable <= 8'h04;
      x0 = nExc;
      pulse(8'h02, 1'h0, 1'h0);
      check("freeze", freezeInternal, 1'h0);
      check("exc req", nExc - x0, 1);
      pulse(8'h04, 1'h0, 1'h0);
      check("freeze", freezeInternal, 1'h1);
      check("pins", freezeStatusPins, NOFREEZE);
      check("halt", moduleHalt, haltEnable);
      check("save_restore_reg0", saveRestore0, pc);
      check("save_restore_reg1", saveRestore1, msr);
      check("cause", causeReg, 8'h06);
      pulse(8'h00, 1'h0, 1'h1);
      check("freeze", freezeInternal, 1'h1);
      pulse(8'h00, 1'h1, 1'h0);
      pulse(8'h00, 1'h0, 1'h1);
      check("freeze", freezeInternal, 1'h0);
      debugModeEnable <= 1'h1;
      pulse(8'h04, 1'h0, 1'h0);
      check("pins", freezeStatusPins, FREEZE_CODE);
      run(6, 16);
      s0 = saveRestore0;
      pulse(8'hff, 1'h0, 1'h0);
      check("save_restore_reg0 hold", saveRestore0, s0);
      srrData <= lfsr(seed);
      srr0Write <= 1'h1;
      @(posedge clk);
      srr0Write <= 1'h0;
      repeat (2) @(posedge clk);
      check("save_restore_reg0 write", saveRestore0, lfsr(seed));
      pulse(8'h00, 1'h1, 1'h0);
      pulse(8'h00, 1'h0, 1'h1);
      check("pins", freezeStatusPins, NOFREEZE);
      run(5, 5);
      print_verdict();
   end
endmodule
`default_nettype wire
